// *** src/alc_defs.svh ***
/*
  Offsets, field positions and reset values of the logic cell cluster.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
`ifndef ALC_DEFS_SVH
`define ALC_DEFS_SVH

// Cell n sits at n*0x10; word index inside the cell slot
`define ALC_CELL_SPAN 12'h080
`define ALC_WD_MASK_LO 2'h0
`define ALC_WD_MASK_HI 2'h1
`define ALC_WD_CELL_CTL 2'h2
`define ALC_OFF_CLU_CTL 12'h080
`define ALC_OFF_STATUS 12'h084

// Cell control word fields
`define ALC_CTL_MODE 0
`define ALC_CTL_PACK_U 3
`define ALC_CTL_CARRY_ONLY 5
`define ALC_CTL_LOCAL_ENA 6
`define ALC_CTL_FLOP_EN_U 7
`define ALC_CTL_FLOP_EN_L 8

// Cluster control word fields
`define ALC_CLU_START0 0
`define ALC_CLU_START4 1
`define ALC_CLU_SPLIT 2
`define ALC_CLU_BYPASS 3
`define ALC_CLU_SLOAD_CARRY 4
`define ALC_CLU_SEED 5

// Reset values
`define ALC_RST_MASK 64'h0
`define ALC_RST_CELL_CTL 9'h180
`define ALC_RST_CLU_CTL 6'h01

`endif

// *** src/alc_pkg.sv ***
/*
  Types of the logic cell cluster: modes, input groups, chain links, state.
  Assumes the constants of alc_defs.svh.
*/
package alc_pkg;

  typedef enum logic [2:0] {
    ALC_NORMAL = 3'b000,
    ALC_SIX = 3'b001,
    ALC_EXT = 3'b010,
    ALC_ARITH = 3'b011,
    ALC_SHARED = 3'b100
  } alc_mode_t;

  // Eight data inputs of one cell from the local interconnect
  typedef struct packed {
    logic shared1;
    logic shared2;
    logic shared3;
    logic shared4;
    logic upper_select_e;
    logic upper_select_f;
    logic lower_select_e;
    logic lower_select_f;
  } alc_data_t;

  // Cluster-wide flop controls
  typedef struct packed {
    logic sync_clear;
    logic sync_load;
    logic async_clear;
    logic async_load;
    logic clock_ena;
  } alc_ctl_t;

  // Carry and shared arithmetic links between clusters
  typedef struct packed {
    logic carry_top;
    logic carry_bot;
    logic share_top;
    logic share_bot;
  } alc_chain_t;

  typedef struct packed {
    logic [7:0][63:0] mask;
    logic [7:0][8:0] cell_ctl;
    logic [5:0] clu_ctl;
    logic [7:0][1:0] flops;
    logic [31:0] prdata;
    logic pslverr;
  } alc_state_t;

endpackage : alc_pkg

// *** src/alc_cluster.sv ***
/*
  One cluster of eight logic cells: LUT halves, full adders, two flops
  per cell, carry and shared arithmetic chains, APB configuration.
  Assumes cell data and cluster controls come from logic on pclk.
*/
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`include "alc_defs.svh"

module alc_cluster #(
  parameter bit TOP_BYPASS = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire alc_pkg::alc_data_t [7:0] cell_data,
  input wire alc_pkg::alc_ctl_t cluster_ctl,
  input wire alc_pkg::alc_chain_t chain_in,
  output alc_pkg::alc_chain_t chain_out,
  output logic [7:0][1:0] comb_out,
  output logic [7:0][1:0] reg_out
);
  import alc_pkg::*;

  localparam alc_state_t ST_RST = '{
    mask: {8{`ALC_RST_MASK}},
    cell_ctl: {8{`ALC_RST_CELL_CTL}},
    clu_ctl: `ALC_RST_CLU_CTL,
    flops: 16'h0000,
    prdata: 32'h0000_0000,
    pslverr: 1'b0
  };

  alc_state_t st_ff;
  alc_state_t nxt_st;
  logic [7:0][1:0] res;
  logic [7:0][1:0] cin;
  logic [7:0][1:0] cout;
  logic [7:0][1:0] pk_in;
  logic [7:0][1:0] ld_in;
  logic [7:0][1:0] fen;
  logic [7:0] cfg_err;
  logic [5:0] clu;
  logic sload;

  assign clu = st_ff.clu_ctl;

  // Per-cell LUT halves, adders and chain links
  genvar i;
  for (i = 0; i < 8; i++) begin : g_cell
    alc_data_t dv;
    logic [63:0] m;
    logic [8:0] ctl;
    alc_mode_t md;
    logic sh;
    logic [3:0] ua, ub, la, lb, ls;
    logic u5, l5, su, sl, xu, q0, q1, q2, q3;
    logic y0, s0, c0, y1, s1, c1;

    assign dv = cell_data[i];
    assign m = st_ff.mask[i];
    assign ctl = st_ff.cell_ctl[i];
    assign md = alc_mode_t'(ctl[`ALC_CTL_MODE +: 3]);
    assign sh = (md == ALC_SHARED);

    // Normal: 5-input halves, shared1/2 common to both
    assign u5 = m[{1'b0, dv.upper_select_f, dv.upper_select_e, dv.shared3, dv.shared2, dv.shared1}];
    assign l5 = m[{1'b1, dv.lower_select_f, dv.lower_select_e, dv.shared4, dv.shared2, dv.shared1}];
    // Six-input: one 64-bit function, private select pairs
    assign su = m[{dv.upper_select_f, dv.upper_select_e, dv.shared4, dv.shared3, dv.shared2, dv.shared1}];
    assign sl = m[{dv.lower_select_f, dv.lower_select_e, dv.shared4, dv.shared3, dv.shared2, dv.shared1}];
    // Extended: upper f picks between two 5-input halves
    assign xu = dv.upper_select_f ?
      m[{1'b1, dv.lower_select_e, dv.shared4, dv.shared3, dv.shared2, dv.shared1}] :
      m[{1'b0, dv.upper_select_e, dv.shared4, dv.shared3, dv.shared2, dv.shared1}];

    // Four 4-input LUTs, all on shared1/2
    assign ua = {dv.upper_select_e, dv.shared3, dv.shared2, dv.shared1};
    assign ub = {dv.upper_select_f, dv.shared4, dv.shared2, dv.shared1};
    assign la = {dv.lower_select_e, dv.shared3, dv.shared2, dv.shared1};
    assign lb = {dv.lower_select_f, dv.shared4, dv.shared2, dv.shared1};
    // Shared mode keeps f inputs out of the LUTs
    assign ls = {dv.lower_select_e, dv.shared4, dv.shared2, dv.shared1};
    assign q0 = m[{2'b00, ua}];
    assign q1 = m[{2'b01, sh ? ua : ub}];
    assign q2 = m[{2'b10, sh ? ls : la}];
    assign q3 = m[{2'b11, sh ? ls : lb}];

    // First adder takes incoming carry, second takes first's carry
    // Shared: upper carry LUT feeds second adder, lower goes on chain
    assign y0 = sh ? cin[i][1] : q1;
    assign s0 = q0 ^ y0 ^ cin[i][0];
    assign c0 = (q0 & y0) | (q0 & cin[i][0]) | (y0 & cin[i][0]);
    assign y1 = sh ? q1 : q3;
    assign s1 = q2 ^ y1 ^ c0;
    assign c1 = (q2 & y1) | (q2 & c0) | (y1 & c0);
    assign cout[i] = {sh & q3, c1};

    // Chain entry: starts only at cell 0 or 4
    if (i == 0) begin : g_c0
      assign cin[i] = clu[`ALC_CLU_START0] ? {1'b0, clu[`ALC_CLU_SEED]} :
        {chain_in.share_top, chain_in.carry_top};
    end else if (i == 4) begin : g_c4
      assign cin[i] = clu[`ALC_CLU_START4] ? {1'b0, clu[`ALC_CLU_SEED]} :
        clu[`ALC_CLU_SPLIT] ? {chain_in.share_bot, chain_in.carry_bot} : cout[3];
    end else begin : g_cn
      assign cin[i] = cout[i - 1];
    end

    // Result per mode
    always_comb begin
      case (md)
        ALC_NORMAL: res[i] = {l5, u5};
        ALC_SIX: res[i] = {sl, su};
        ALC_EXT: res[i] = {1'b0, xu};
        ALC_ARITH: res[i] = ctl[`ALC_CTL_CARRY_ONLY] ? {q2, q0} : {s1, s0};
        ALC_SHARED: res[i] = {s1, s0};
        default: res[i] = 2'b00;
      endcase
    end

    // Packing sources; extended mode packs the eighth input upstairs
    assign pk_in[i] = {dv.lower_select_f,
      (md == ALC_EXT) ? dv.lower_select_f : dv.upper_select_f};
    assign ld_in[i] = {dv.lower_select_e, dv.upper_select_e};
    // Flop enables: lower flop off in extended mode, local enable on shared3 in arithmetic mode only
    assign fen[i] = ctl[`ALC_CTL_FLOP_EN_U +: 2] & {md != ALC_EXT, 1'b1} &
      {2{~(ctl[`ALC_CTL_LOCAL_ENA] & (md == ALC_ARITH)) | dv.shared3}};
    assign cfg_err[i] = ((md == ALC_EXT) & ctl[`ALC_CTL_FLOP_EN_L]) |
      (ctl[`ALC_CTL_MODE +: 3] > 3'b100);
  end

  // Chain exits: full, half or bypassed per column kind
  always_comb begin
    chain_out.carry_top = clu[`ALC_CLU_SPLIT] ? cout[3][0] : cout[7][0];
    chain_out.share_top = clu[`ALC_CLU_SPLIT] ? cout[3][1] : cout[7][1];
    chain_out.carry_bot = cout[7][0];
    chain_out.share_bot = cout[7][1];
    if (clu[`ALC_CLU_BYPASS] && TOP_BYPASS) begin
      chain_out.carry_top = chain_in.carry_top;
      chain_out.share_top = chain_in.share_top;
    end
    if (clu[`ALC_CLU_BYPASS] && !TOP_BYPASS) begin
      chain_out.carry_bot = chain_in.carry_bot;
      chain_out.share_bot = chain_in.share_bot;
    end
  end

  // Chain carry may act as cluster sync load
  assign sload = cluster_ctl.sync_load | (clu[`ALC_CLU_SLOAD_CARRY] & cout[7][0]);

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8 * b +: 8] = wd[8 * b +: 8];
      end
    end
    return r;
  endfunction : strb_merge

  // Next state: APB slave and the cell flops
  always_comb begin
    logic [2:0] ci;
    logic [1:0] wd;
    logic cell_hit, clu_hit, sts_hit;
    logic [31:0] cur, rd, nw, nc;
    logic d;
    nxt_st = st_ff;
    d = 1'b0;
    ci = paddr[6:4];
    wd = paddr[3:2];
    cell_hit = (paddr < `ALC_CELL_SPAN) && (paddr[1:0] == 2'h0) && (wd != 2'h3);
    clu_hit = (paddr == `ALC_OFF_CLU_CTL);
    sts_hit = (paddr == `ALC_OFF_STATUS);
    case (wd)
      `ALC_WD_MASK_LO: cur = st_ff.mask[ci][31:0];
      `ALC_WD_MASK_HI: cur = st_ff.mask[ci][63:32];
      default: cur = {23'h0, st_ff.cell_ctl[ci]};
    endcase
    rd = cell_hit ? cur : clu_hit ? {26'h0, clu} :
      sts_hit ? {6'h0, cfg_err, chain_out.carry_bot, chain_out.carry_top, st_ff.flops} : 32'h0;
    nw = strb_merge(cur, pwdata, pstrb);
    // Cluster control merged apart from the cell words
    nc = strb_merge({26'h0, clu}, pwdata, pstrb);
    // Setup phase latches read data and the error answer
    if (psel && !penable) begin
      nxt_st.prdata = pwrite ? 32'h0 : rd;
      nxt_st.pslverr = !(cell_hit || clu_hit || sts_hit) || (pwrite && sts_hit);
    end
    // Access phase commits the write
    if (psel && penable && pwrite && !st_ff.pslverr) begin
      if (cell_hit) begin
        case (wd)
          `ALC_WD_MASK_LO: nxt_st.mask[ci][31:0] = nw;
          `ALC_WD_MASK_HI: nxt_st.mask[ci][63:32] = nw;
          default: nxt_st.cell_ctl[ci] = nw[8:0];
        endcase
      end
      if (clu_hit) begin
        nxt_st.clu_ctl = nc[5:0];
      end
    end
    // Cell flops: clear over load, then enable, sync clear, sync load
    for (int k = 0; k < 8; k++) begin
      for (int h = 0; h < 2; h++) begin
        d = st_ff.cell_ctl[k][`ALC_CTL_PACK_U + h] ? pk_in[k][h] : res[k][h];
        if (cluster_ctl.async_clear) begin
          nxt_st.flops[k][h] = 1'b0;
        end else if (cluster_ctl.async_load) begin
          nxt_st.flops[k][h] = ld_in[k][h];
        end else if (cluster_ctl.clock_ena && fen[k][h]) begin
          if (cluster_ctl.sync_clear) begin
            nxt_st.flops[k][h] = 1'b0;
          end else if (sload) begin
            nxt_st.flops[k][h] = ld_in[k][h];
          end else begin
            nxt_st.flops[k][h] = d;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pslverr = st_ff.pslverr;
  assign pready = 1'b1;
  assign comb_out = res;
  assign reg_out = st_ff.flops;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic quiet0;
  assign quiet0 = !cluster_ctl.async_clear && !cluster_ctl.async_load;

  property p_clr_wins;
    cluster_ctl.async_clear && cluster_ctl.async_load |=> reg_out == 16'h0000;
  endproperty
  a_clr_wins: assert property (p_clr_wins) else $error("clear lost to load");

  property p_aload;
    !cluster_ctl.async_clear && cluster_ctl.async_load |=> reg_out[0][0] == $past(cell_data[0].upper_select_e);
  endproperty
  a_aload: assert property (p_aload) else $error("async load data wrong");

  property p_reg_both;
    quiet0 && cluster_ctl.clock_ena && fen[0][0] && !cluster_ctl.sync_clear && !sload &&
      !st_ff.cell_ctl[0][`ALC_CTL_PACK_U] |=> reg_out[0][0] == $past(comb_out[0][0]);
  endproperty
  a_reg_both: assert property (p_reg_both) else $error("flop missed result");

  property p_sload_carry;
    quiet0 && cluster_ctl.clock_ena && fen[1][1] && !cluster_ctl.sync_clear &&
      clu[`ALC_CLU_SLOAD_CARRY] && cout[7][0] |=> reg_out[1][1] == $past(cell_data[1].lower_select_e);
  endproperty
  a_sload_carry: assert property (p_sload_carry) else $error("carry did not sync load");

  property p_ext_hold;
    quiet0 && g_cell[0].md == ALC_EXT |=> $stable(reg_out[0][1]);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("lower flop moved in ext mode");

  property p_ce_hold;
    quiet0 && !cluster_ctl.clock_ena |=> $stable(reg_out);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("flops moved without enable");

  property p_carry_only;
    g_cell[0].md == ALC_ARITH && st_ff.cell_ctl[0][`ALC_CTL_CARRY_ONLY] |-> comb_out[0][0] == g_cell[0].q0;
  endproperty
  a_carry_only: assert property (p_carry_only) else $error("sum not ignored");

  property p_half_entry;
    clu[`ALC_CLU_SPLIT] && !clu[`ALC_CLU_START4] |-> cin[4][0] == chain_in.carry_bot;
  endproperty
  a_half_entry: assert property (p_half_entry) else $error("bottom half entry wrong");

  property p_bypass;
    clu[`ALC_CLU_BYPASS] && TOP_BYPASS |-> chain_out.carry_top == chain_in.carry_top;
  endproperty
  a_bypass: assert property (p_bypass) else $error("top bypass broken");

  property p_six_same;
    g_cell[0].md == ALC_SIX && cell_data[0].upper_select_e == cell_data[0].lower_select_e &&
      cell_data[0].upper_select_f == cell_data[0].lower_select_f |-> comb_out[0][0] == comb_out[0][1];
  endproperty
  a_six_same: assert property (p_six_same) else $error("six-input halves differ");

  // Adder, chain, flop control and extended-mode output checks
  property p_adder_pair;
    g_cell[0].md == ALC_ARITH |-> {g_cell[0].c1, g_cell[0].s1, g_cell[0].s0} ==
      {g_cell[0].q2, g_cell[0].q0} + {g_cell[0].q3, g_cell[0].q1} + cin[0][0];
  endproperty
  a_adder_pair: assert property (p_adder_pair) else $error("arith adder pair wrong");

  property p_shared_add;
    g_cell[1].md == ALC_SHARED |-> {g_cell[1].c0, g_cell[1].s0} == g_cell[1].q0 + cout[0][1] + cout[0][0];
  endproperty
  a_shared_add: assert property (p_shared_add) else $error("shared chain add wrong");

  property p_split_top;
    clu[`ALC_CLU_SPLIT] && !clu[`ALC_CLU_BYPASS] |-> chain_out.carry_top == cout[3][0];
  endproperty
  a_split_top: assert property (p_split_top) else $error("top half exit wrong");

  property p_sync_clear;
    quiet0 && cluster_ctl.clock_ena && fen[0][0] && cluster_ctl.sync_clear |=> reg_out[0][0] == 1'b0;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("sync clear missed");

  property p_sload_data;
    quiet0 && cluster_ctl.clock_ena && fen[0][1] && !cluster_ctl.sync_clear && sload |=>
      reg_out[0][1] == $past(cell_data[0].lower_select_e);
  endproperty
  a_sload_data: assert property (p_sload_data) else $error("sync load data wrong");

  property p_ext_lower;
    g_cell[0].md == ALC_EXT |-> comb_out[0][1] == 1'b0;
  endproperty
  a_ext_lower: assert property (p_ext_lower) else $error("lower output live in ext mode");

  c_arith_carry: cover property (g_cell[7].md == ALC_ARITH && cout[7][0]);
  c_ext: cover property (g_cell[0].md == ALC_EXT && cell_data[0].upper_select_f);
  c_split: cover property (clu[`ALC_CLU_SPLIT] && chain_out.carry_top != chain_out.carry_bot);
  c_shared: cover property (g_cell[1].md == ALC_SHARED && cout[0][1]);
  c_csel: cover property (g_cell[0].md == ALC_ARITH && st_ff.cell_ctl[0][`ALC_CTL_CARRY_ONLY] && sload);

endmodule : alc_cluster

// *** testbench/alc_fabric_model.sv ***
/*
  Model of the cluster interconnect and neighbour cluster feeding the cells.
  Assumes the bench sets the next values just after a rising edge of pclk.
*/
`timescale 1ns/100ps
module alc_fabric_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire alc_pkg::alc_data_t [7:0] nxt_cells,
  input wire alc_pkg::alc_ctl_t nxt_ctl,
  input wire alc_pkg::alc_chain_t nxt_chain,
  output alc_pkg::alc_data_t [7:0] cell_data,
  output alc_pkg::alc_ctl_t cluster_ctl,
  output alc_pkg::alc_chain_t chain_in
);
  import alc_pkg::*;
  // Routed values land one edge after they are asked for
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_data <= '0; // All eight cells fed together
      cluster_ctl <= '0;
      chain_in <= '0;
    end else begin
      cell_data <= nxt_cells;
      cluster_ctl <= nxt_ctl;
      chain_in <= nxt_chain; // Link from the cluster below
    end
  end
endmodule : alc_fabric_model

// *** testbench/adaptive_logic_cell_modes_test.sv ***
/*
  Self-checking bench of one logic cell cluster: registers, modes, chains, flops.
  Assumes alc_defs.svh on the include path and the fabric model beside it.
*/
`timescale 1ns/100ps
`include "alc_defs.svh"
`define chk(nm, exp_v, got_v) begin \
  cmp_count++; \
  if ((got_v) !== (exp_v)) begin \
    miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, exp_v, got_v); \
  end \
end
module adaptive_logic_cell_modes_test;
  import alc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  alc_data_t [7:0] nxt_cells = '0;
  alc_ctl_t nxt_ctl = '0;
  alc_chain_t nxt_chain = '0;
  alc_data_t [7:0] cell_data;
  alc_ctl_t cluster_ctl;
  alc_chain_t chain_in;
  alc_chain_t chain_out;
  logic [7:0][1:0] comb_out;
  logic [7:0][1:0] reg_out;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  localparam alc_ctl_t CE = 5'h01;

  alc_cluster #(.TOP_BYPASS(1'b1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cell_data(cell_data), .cluster_ctl(cluster_ctl), .chain_in(chain_in),
    .chain_out(chain_out), .comb_out(comb_out), .reg_out(reg_out));
  alc_fabric_model fabric (.pclk(pclk), .presetn(presetn), .nxt_cells(nxt_cells), .nxt_ctl(nxt_ctl),
    .nxt_chain(nxt_chain), .cell_data(cell_data), .cluster_ctl(cluster_ctl), .chain_in(chain_in));

  // 100 MHz clock
  always #5 pclk = ~pclk;

  // Cuts a hung run short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // One APB transfer, held until pready at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
    `chk("write error", 1'b0, err)
  endtask : wr

  task automatic cfg(input logic [2:0] n, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] ctl);
    wr({5'h0, n, 4'h0}, lo);
    wr({5'h0, n, 4'h4}, hi);
    wr({5'h0, n, 4'h8}, ctl);
  endtask : cfg

  // Inputs reach the cells one edge later, flops one edge after that
  task automatic apply(input alc_data_t [7:0] d, input alc_ctl_t c, input alc_chain_t ch);
    @(posedge pclk);
    nxt_cells <= d;
    nxt_ctl <= c;
    nxt_chain <= ch;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : apply

  // Lane 2k of a and b on the upper pair of cell k, lane 2k+1 on the lower pair
  function automatic alc_data_t [7:0] mk(input logic [15:0] a, input logic [15:0] b);
    alc_data_t [7:0] d;
    d = '0;
    for (int k = 0; k < 8; k++) begin
      d[k].upper_select_e = a[2*k];
      d[k].upper_select_f = b[2*k];
      d[k].lower_select_e = a[2*k+1];
      d[k].lower_select_f = b[2*k+1];
    end
    return d;
  endfunction : mk

  task automatic t_regs();
    apb(1'b0, 12'h038, 32'h0, rd, err);
    `chk("cell ctl reset", 32'h0000_0180, rd)
    apb(1'b0, `ALC_OFF_CLU_CTL, 32'h0, rd, err);
    `chk("cluster ctl reset", 32'h0000_0001, rd)
    apb(1'b0, 12'h00c, 32'h0, rd, err);
    `chk("unmapped", 33'h1_0000_0000, {err, rd})
    apb(1'b1, `ALC_OFF_STATUS, 32'hffff_ffff, rd, err);
    `chk("status write", 1'b1, err)
    wr(12'h058, 32'hffff_ffff);
    apb(1'b0, 12'h058, 32'h0, rd, err);
    `chk("cell ctl width", 32'h0000_01ff, rd)
    apb(1'b0, `ALC_OFF_STATUS, 32'h0, rd, err);
    `chk("config error", 1'b1, rd[23])
    wr(12'h058, 32'h0000_0180);
  endtask : t_regs

  task automatic t_ext();
    logic x;
    cfg(3'h0, 32'hffff_0000, 32'h0000_ffff, 32'h0000_0092);
    for (int i = 0; i < 8; i++) begin
      x = i[2] ? ~i[1] : i[0];
      apply(mk({14'h0, i[1], i[0]}, {14'h0, 1'b1, i[2]}), CE, '0);
      `chk("ext comb", {1'b0, x}, comb_out[0])
      `chk("ext flops", {1'b0, x}, reg_out[0])
    end
  endtask : t_ext

  task automatic t_norm(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] ctl, input logic six);
    logic [1:0] x;
    cfg(3'h0, lo, hi, ctl);
    for (int i = 0; i < 16; i++) begin
      x = six ? {i[3], i[1]} : {i[2] ^ i[3], i[0] & i[1]};
      apply(mk({14'h0, i[2], i[0]}, {14'h0, i[3], i[1]}), CE, '0);
      `chk("lut comb", x, comb_out[0])
      `chk("lut flops", x, reg_out[0])
    end
  endtask : t_norm

  task automatic t_add(input logic [31:0] clu, input alc_chain_t ch, input logic [15:0] a, input logic [15:0] b,
                       input logic [15:0] s, input logic [15:0] r, input logic ct, input logic cb);
    wr(`ALC_OFF_CLU_CTL, clu);
    apply(mk(a, b), CE, ch);
    `chk("sum", s, comb_out)
    `chk("flops", r, reg_out)
    `chk("carry out", {ct, cb}, {chain_out.carry_top, chain_out.carry_bot})
  endtask : t_add

  task automatic t_arith();
    for (int k = 0; k < 8; k++) begin
      cfg(k[2:0], 32'hff00_ff00, 32'hff00_ff00, 32'h0000_0183);
    end
    t_add(32'h01, '0, 16'hffff, 16'h0001, 16'h0000, 16'h0000, 1'b1, 1'b1);
    t_add(32'h21, '0, 16'h1234, 16'h0f0f, 16'h2144, 16'h2144, 1'b0, 1'b0);
  endtask : t_arith

  task automatic t_csel();
    t_add(32'h11, '0, 16'hffff, 16'h0001, 16'h0000, 16'hffff, 1'b1, 1'b1);
    t_add(32'h11, '0, 16'h1234, 16'h0f0f, 16'h2143, 16'h2143, 1'b0, 1'b0);
    // Carry-only: LUT outputs shown while the carry still drives sync load
    for (int k = 0; k < 8; k++) begin
      wr({5'h0, k[2:0], 4'h8}, 32'h0000_01a3);
    end
    t_add(32'h11, '0, 16'hffff, 16'h0001, 16'hffff, 16'hffff, 1'b1, 1'b1);
    for (int k = 0; k < 8; k++) begin
      wr({5'h0, k[2:0], 4'h8}, 32'h0000_0183);
    end
  endtask : t_csel

  task automatic t_chain();
    t_add(32'h07, '0, 16'hffff, 16'h0001, 16'hff00, 16'hff00, 1'b1, 1'b0);
    t_add(32'h05, '0, 16'hffff, 16'h0001, 16'hff00, 16'hff00, 1'b1, 1'b0);
    t_add(32'h00, 4'h8, 16'h0000, 16'h0000, 16'h0001, 16'h0001, 1'b0, 1'b0);
    t_add(32'h0f, '0, 16'hffff, 16'h0001, 16'hff00, 16'hff00, 1'b0, 1'b0);
  endtask : t_chain

  // Cells 0 and 1 in shared mode, carry LUT of cell 0 on the shared chain
  task automatic t_shared();
    wr(12'h008, 32'h0000_0184);
    wr(12'h018, 32'h0000_0184);
    t_add(32'h01, '0, 16'h000b, 16'h000f, 16'h0011, 16'h0011, 1'b0, 1'b0);
  endtask : t_shared

  task automatic t_flop();
    cfg(3'h0, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_0180);
    apply(mk(16'h0, 16'h0), CE, '0);
    `chk("load comb", 2'h3, reg_out[0])
    apply(mk(16'h0, 16'h0), 5'h11, '0);
    `chk("sync clear", 16'h0, reg_out)
    apply(mk(16'h0, 16'h0), 5'h00, '0);
    `chk("enable off", 2'h0, reg_out[0])
    apply(mk(16'h1, 16'h0), 5'h03, '0);
    `chk("async load", 2'h1, reg_out[0])
    apply(mk(16'h1, 16'h0), 5'h07, '0);
    `chk("clear wins", 2'h0, reg_out[0])
    apply(mk(16'h2, 16'h0), 5'h09, '0);
    `chk("sync load", 2'h2, reg_out[0])
  endtask : t_flop

  // Reset, then every scenario in turn
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_ext();
    t_norm(32'hff00_0000, 32'h00ff_ff00, 32'h0000_0180, 1'b0);
    t_norm(32'h0000_0000, 32'hffff_ffff, 32'h0000_0181, 1'b1);
    t_arith();
    t_csel();
    t_chain();
    t_shared();
    t_flop();
    end_of_test();
  end
endmodule : adaptive_logic_cell_modes_test
